// [design/dcc_top.sv]
// How it works
// - Commands decode from chip select, activate, shared pins, clock enable each edge.
// - Activate high: shared pins are command; low: row bits 16 to 14.
// - Bank group and bank pick bank, or mode register on mode set.
// - Bursts always complete; fixed or per-command length comes from mode setting.
// - Termination input never affects state; termination off during self refresh.
// - Power-down performs no refresh of its own.
// - Transitions use previous and present clock enable and present command.
// - Self refresh entered only from idle by refresh with enable falling.
// - Power-down entry is precharge type if banks closed, else active type.
// - Idle means banks closed, no burst, enable high, timings elapsed.
// - Undefined enable and command combinations are flagged illegal.
// - Reset is active low; normal functions need it high.
// - Self refresh exit is detected synchronously to the clock.
// - Deselect executes nothing new; ongoing operations continue.
// - Clearing the loop control bit disables the loop until set again.
// - Loop-off mode uses read latency 10 and write latency 9.
// - Loop-off read strobe window starts one cycle earlier than loop-on.
`timescale 1ns/100ps
`default_nettype none
module dcc_top #(
   parameter int XSDLL_CYC = dcc_pkg::DCC_XSDLL_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic act_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [1:0] bg_i,
   input wire logic [1:0] ba_i,
   input wire logic [13:0] addr_i,
   input wire logic odt_i,
   input wire logic [4:0] additive_latency_i,
   output dcc_pkg::dcc_cmd_type cmd_o,
   output logic cmd_valid_o,
   output logic [1:0] bank_group_o,
   output logic [1:0] bank_o,
   output logic [2:0] mode_reg_sel_o,
   output logic [16:0] row_addr_o,
   output logic [13:0] mode_op_o,
   output dcc_pkg::dcc_state_type state_o,
   output logic idle_o,
   output logic burst_active_o,
   output logic burst_is_read_o,
   output logic dll_enable_o,
   output logic [4:0] read_latency_o,
   output logic [4:0] write_latency_o,
   output logic [4:0] strobe_start_o,
   output logic odt_active_o,
   output logic self_refresh_o,
   output logic refresh_allowed_o,
   output logic read_allowed_o,
   output logic illegal_o
);
   dcc_pkg::dcc_cmd_type dec_cmd;
   dcc_pkg::dcc_cmd_type next_cmd;
   dcc_pkg::dcc_state_type state, next_state;
   logic cke_prev, next_cke_prev;
   logic cmd_valid, next_cmd_valid;
   logic [1:0] bank_group, next_bank_group;
   logic [1:0] bank, next_bank;
   logic [2:0] mode_reg_sel, next_mode_reg_sel;
   logic [16:0] row_addr, next_row_addr;
   logic [13:0] mode_op, next_mode_op;
   logic [dcc_pkg::DCC_NBANK-1:0] open_banks, next_open_banks;
   logic [2:0] burst_cnt, next_burst_cnt;
   logic burst_rd, next_burst_rd;
   logic dll_en, next_dll_en;
   logic bl_otf, next_bl_otf;
   logic [4:0] rl, next_rl;
   logic [4:0] wl, next_wl;
   logic [dcc_pkg::DCC_CNT_W-1:0] xs_cnt, next_xs_cnt;
   logic [dcc_pkg::DCC_CNT_W-1:0] xsdll_cnt, next_xsdll_cnt;
   logic illegal, next_illegal;
   logic pd_entry, pd_exit, sr_entry, sr_exit, is_idle;

   // Flat bank index from group and bank
   function automatic logic [3:0] dcc_bank_idx(input logic [1:0] g, input logic [1:0] b);
      dcc_bank_idx = {g, b};
   endfunction

   // Burst length in beat pairs less one, from the chop pin
   function automatic logic [2:0] dcc_burst_len(input logic otf, input logic chop_n);
      dcc_burst_len = (otf && !chop_n) ? dcc_pkg::DCC_BC4_BEATS : dcc_pkg::DCC_BL8_BEATS;
   endfunction

   // Command decode of the sampled pins
   dcc_decode u_decode (
      .cs_n_i(cs_n_i),
      .act_n_i(act_n_i),
      .ras_n_i(ras_n_i),
      .cas_n_i(cas_n_i),
      .we_n_i(we_n_i),
      .a10_i(addr_i[dcc_pkg::DCC_A10_POS]),
      .cmd_o(dec_cmd)
   );

   // Clock enable edge classification from previous and present level
   always_comb begin
      is_idle = (open_banks == '0) && (burst_cnt == dcc_pkg::DCC_BURST_IDLE)
         && cke_prev && (state == dcc_pkg::DCC_ST_ACTIVE)
         && (xs_cnt == '0) && (xsdll_cnt == '0);
      pd_entry = cke_prev && !cke_i && (dec_cmd == dcc_pkg::DCC_CMD_DES);
      sr_entry = cke_prev && !cke_i && (dec_cmd == dcc_pkg::DCC_CMD_REF) && is_idle;
      pd_exit = !cke_prev && cke_i && (dec_cmd == dcc_pkg::DCC_CMD_DES);
      sr_exit = pd_exit && (state == dcc_pkg::DCC_ST_SELF_REF);
   end

   // State, decode capture, banks, bursts and mode settings
   always_comb begin
      next_state = state;
      next_cke_prev = cke_i;
      next_cmd = dcc_pkg::DCC_CMD_DES;
      next_cmd_valid = 1'b0;
      next_bank_group = bank_group;
      next_bank = bank;
      next_mode_reg_sel = mode_reg_sel;
      next_row_addr = row_addr;
      next_mode_op = mode_op;
      next_open_banks = open_banks;
      next_burst_rd = burst_rd;
      next_dll_en = dll_en;
      next_bl_otf = bl_otf;
      next_rl = rl;
      next_wl = wl;
      next_illegal = 1'b0;
      next_xs_cnt = xs_cnt;
      next_xsdll_cnt = xsdll_cnt;
      // Bursts run on regardless of new commands
      next_burst_cnt = (burst_cnt != dcc_pkg::DCC_BURST_IDLE) ? burst_cnt - 3'h1 : burst_cnt;
      if (xs_cnt != '0) begin
         next_xs_cnt = xs_cnt - 1'b1;
      end
      if (xsdll_cnt != '0) begin
         next_xsdll_cnt = xsdll_cnt - 1'b1;
      end
      unique case (state)
         dcc_pkg::DCC_ST_PRE_PD, dcc_pkg::DCC_ST_ACT_PD: begin
            // No refresh activity while powered down
            if (pd_exit) begin
               next_state = dcc_pkg::DCC_ST_ACTIVE;
            end else if (!cke_prev && cke_i) begin
               next_illegal = 1'b1;
            end
         end
         dcc_pkg::DCC_ST_SELF_REF: begin
            if (sr_exit) begin
               next_state = dcc_pkg::DCC_ST_SR_EXIT;
               next_xs_cnt = dcc_pkg::DCC_CNT_W'(dcc_pkg::DCC_XS_CYC);
               next_xsdll_cnt = dcc_pkg::DCC_CNT_W'(XSDLL_CYC);
            end else if (!cke_prev && cke_i) begin
               next_illegal = 1'b1;
            end
         end
         dcc_pkg::DCC_ST_SR_EXIT: begin
            if (dec_cmd != dcc_pkg::DCC_CMD_DES || !cke_i) begin
               next_illegal = 1'b1;
            end
            if (xs_cnt == '0) begin
               next_state = dcc_pkg::DCC_ST_ACTIVE;
            end
         end
         dcc_pkg::DCC_ST_ACTIVE: begin
            if (cke_prev && !cke_i) begin
               if (sr_entry) begin
                  next_state = dcc_pkg::DCC_ST_SELF_REF;
               end else if (pd_entry) begin
                  next_state = (open_banks == '0) ? dcc_pkg::DCC_ST_PRE_PD
                     : dcc_pkg::DCC_ST_ACT_PD;
               end else begin
                  next_illegal = 1'b1;
               end
            end else if (!cke_prev) begin
               next_illegal = 1'b1;
            end else if (dec_cmd != dcc_pkg::DCC_CMD_DES) begin
               next_cmd = dec_cmd;
               next_cmd_valid = 1'b1;
               next_bank_group = bg_i;
               next_bank = ba_i;
               unique case (dec_cmd)
                  dcc_pkg::DCC_CMD_ACT: begin
                     next_row_addr = {ras_n_i, cas_n_i, we_n_i, addr_i};
                     next_open_banks[dcc_bank_idx(bg_i, ba_i)] = 1'b1;
                  end
                  dcc_pkg::DCC_CMD_PRE: begin
                     next_open_banks[dcc_bank_idx(bg_i, ba_i)] = 1'b0;
                  end
                  dcc_pkg::DCC_CMD_PREA: begin
                     next_open_banks = '0;
                  end
                  dcc_pkg::DCC_CMD_RD, dcc_pkg::DCC_CMD_WR: begin
                     if (burst_cnt != dcc_pkg::DCC_BURST_IDLE
                        || (dec_cmd == dcc_pkg::DCC_CMD_RD && xsdll_cnt != '0)) begin
                        next_illegal = 1'b1;
                     end else begin
                        next_burst_cnt = dcc_burst_len(bl_otf,
                           addr_i[dcc_pkg::DCC_A12_POS]);
                        next_burst_rd = (dec_cmd == dcc_pkg::DCC_CMD_RD);
                     end
                     if (addr_i[dcc_pkg::DCC_A10_POS]) begin
                        next_open_banks[dcc_bank_idx(bg_i, ba_i)] = 1'b0;
                     end
                  end
                  dcc_pkg::DCC_CMD_MRS: begin
                     next_mode_reg_sel = {bg_i[0], ba_i};
                     next_mode_op = addr_i;
                     if ({bg_i[0], ba_i} == dcc_pkg::DCC_MR1_IDX) begin
                        next_dll_en = addr_i[dcc_pkg::DCC_MR1_DLL_POS];
                     end
                     if ({bg_i[0], ba_i} == dcc_pkg::DCC_MR0_IDX) begin
                        next_bl_otf = (addr_i[1:0] == dcc_pkg::DCC_BL_OTF);
                        next_rl = addr_i[6:2];
                     end
                     if ({bg_i[0], ba_i} == dcc_pkg::DCC_MR2_IDX) begin
                        next_wl = addr_i[7:3];
                     end
                  end
                  dcc_pkg::DCC_CMD_RFU: begin
                     next_illegal = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
      endcase
   end

   // Register all state; synchronous active-low reset
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         state <= dcc_pkg::DCC_ST_ACTIVE;
         cke_prev <= 1'b1; // Pin idle level, so no false edge after reset
         cmd_o <= dcc_pkg::DCC_CMD_DES;
         cmd_valid <= 1'b0;
         bank_group <= '0;
         bank <= '0;
         mode_reg_sel <= '0;
         row_addr <= '0;
         mode_op <= '0;
         open_banks <= '0;
         burst_cnt <= dcc_pkg::DCC_BURST_IDLE;
         burst_rd <= 1'b0;
         dll_en <= 1'b1;
         bl_otf <= 1'b0;
         rl <= dcc_pkg::DCC_DLL_OFF_RL;
         wl <= dcc_pkg::DCC_DLL_OFF_WL;
         xs_cnt <= '0;
         xsdll_cnt <= '0;
         illegal <= 1'b0;
      end else begin
         state <= next_state;
         cke_prev <= next_cke_prev;
         cmd_o <= next_cmd;
         cmd_valid <= next_cmd_valid;
         bank_group <= next_bank_group;
         bank <= next_bank;
         mode_reg_sel <= next_mode_reg_sel;
         row_addr <= next_row_addr;
         mode_op <= next_mode_op;
         open_banks <= next_open_banks;
         burst_cnt <= next_burst_cnt;
         burst_rd <= next_burst_rd;
         dll_en <= next_dll_en;
         bl_otf <= next_bl_otf;
         rl <= next_rl;
         wl <= next_wl;
         xs_cnt <= next_xs_cnt;
         xsdll_cnt <= next_xsdll_cnt;
         illegal <= next_illegal;
      end
   end

   // Output mapping
   assign cmd_valid_o = cmd_valid;
   assign bank_group_o = bank_group;
   assign bank_o = bank;
   assign mode_reg_sel_o = mode_reg_sel;
   assign row_addr_o = row_addr;
   assign mode_op_o = mode_op;
   assign state_o = state;
   assign idle_o = is_idle;
   assign burst_active_o = (burst_cnt != dcc_pkg::DCC_BURST_IDLE);
   assign burst_is_read_o = burst_rd;
   assign dll_enable_o = dll_en;
   // Loop-off forces the single supported latency pair
   assign read_latency_o = dll_en ? rl : dcc_pkg::DCC_DLL_OFF_RL;
   assign write_latency_o = dll_en ? wl : dcc_pkg::DCC_DLL_OFF_WL;
   // Strobe window start counted from the read command
   assign strobe_start_o = dll_en ? additive_latency_i + read_latency_o
      : additive_latency_i + read_latency_o - dcc_pkg::DCC_DLL_OFF_SHIFT;
   // Termination follows its pin only outside self refresh
   assign odt_active_o = odt_i && (state != dcc_pkg::DCC_ST_SELF_REF);
   assign self_refresh_o = (state == dcc_pkg::DCC_ST_SELF_REF);
   assign refresh_allowed_o = (state == dcc_pkg::DCC_ST_ACTIVE) || self_refresh_o;
   assign read_allowed_o = (xsdll_cnt == '0) && (state == dcc_pkg::DCC_ST_ACTIVE);
   assign illegal_o = illegal;
endmodule
`default_nettype wire

// [design/dcc_pkg.sv]
package dcc_pkg;
   // Command decode results
   typedef enum logic [3:0] {
      DCC_CMD_DES,
      DCC_CMD_NOP,
      DCC_CMD_MRS,
      DCC_CMD_REF,
      DCC_CMD_PRE,
      DCC_CMD_PREA,
      DCC_CMD_ACT,
      DCC_CMD_WR,
      DCC_CMD_RD,
      DCC_CMD_ZQCL,
      DCC_CMD_ZQCS,
      DCC_CMD_RFU
   } dcc_cmd_type;

   // Clock-enable power states
   typedef enum logic [2:0] {
      DCC_ST_ACTIVE,
      DCC_ST_PRE_PD,
      DCC_ST_ACT_PD,
      DCC_ST_SELF_REF,
      DCC_ST_SR_EXIT
   } dcc_state_type;

   // Field widths
   localparam int DCC_BG_W = 2;
   localparam int DCC_BA_W = 2;
   localparam int DCC_ROW_W = 17;
   localparam int DCC_NBANK = 16;
   localparam int DCC_CNT_W = 10;

   // Pin positions inside the address bus
   localparam int DCC_A10_POS = 10;
   localparam int DCC_A12_POS = 12;

   // Mode register fields
   localparam logic [2:0] DCC_MR0_IDX = 3'h0;
   localparam logic [2:0] DCC_MR1_IDX = 3'h1;
   localparam logic [2:0] DCC_MR2_IDX = 3'h2;
   localparam int DCC_MR1_DLL_POS = 0;
   localparam int DCC_MR0_BL_POS = 0;

   // Burst and latency constants
   localparam logic [2:0] DCC_BL8_BEATS = 3'h3;
   localparam logic [2:0] DCC_BC4_BEATS = 3'h1;
   localparam logic [1:0] DCC_BL_OTF = 2'h1;
   localparam logic [4:0] DCC_DLL_OFF_RL = 5'h0A;
   localparam logic [4:0] DCC_DLL_OFF_WL = 5'h09;
   localparam logic [4:0] DCC_DLL_OFF_SHIFT = 5'h01;

   // Timing, in ns, and clock period
   localparam int DCC_CLK_NS = 100;
   localparam int DCC_XS_NS = 400;
   localparam int DCC_XSDLL_NS = 60000;
   localparam int DCC_CKE_NS = 500;

   // Cycle counts, least times rounded up
   localparam int DCC_XS_CYC = (DCC_XS_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;
   localparam int DCC_XSDLL_CYC = (DCC_XSDLL_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;
   localparam int DCC_CKE_CYC = (DCC_CKE_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;

   // Reset values
   localparam logic [2:0] DCC_BURST_IDLE = 3'h0;
endpackage

// [design/dcc_decode.sv]
`timescale 1ns/100ps
`default_nettype none
// Pure command decode of the sampled command pins
module dcc_decode (
   input wire logic cs_n_i,
   input wire logic act_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic a10_i,
   output dcc_pkg::dcc_cmd_type cmd_o
);
   // Shared pins act as command inputs only with the activate strobe high
   always_comb begin
      cmd_o = dcc_pkg::DCC_CMD_RFU;
      if (cs_n_i) begin
         cmd_o = dcc_pkg::DCC_CMD_DES;
      end else if (!act_n_i) begin
         cmd_o = dcc_pkg::DCC_CMD_ACT;
      end else begin
         unique case ({ras_n_i, cas_n_i, we_n_i})
            3'h0: cmd_o = dcc_pkg::DCC_CMD_MRS;
            3'h1: cmd_o = dcc_pkg::DCC_CMD_REF;
            3'h2: cmd_o = dcc_pkg::DCC_CMD_PRE;
            3'h3: cmd_o = dcc_pkg::DCC_CMD_RFU;
            3'h4: cmd_o = dcc_pkg::DCC_CMD_WR;
            3'h5: cmd_o = dcc_pkg::DCC_CMD_RD;
            3'h6: cmd_o = a10_i ? dcc_pkg::DCC_CMD_ZQCL : dcc_pkg::DCC_CMD_ZQCS;
            3'h7: cmd_o = dcc_pkg::DCC_CMD_NOP;
         endcase
         if (cmd_o == dcc_pkg::DCC_CMD_PRE && a10_i) begin
            cmd_o = dcc_pkg::DCC_CMD_PREA;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/dcc_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// Port checks of command decode and clock-enable states
module dcc_top_sva #(
   parameter int XSDLL_CYC = 8
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic act_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [1:0] bg_i,
   input wire logic [1:0] ba_i,
   input wire logic [13:0] addr_i,
   input wire logic [4:0] additive_latency_i,
   input wire dcc_pkg::dcc_cmd_type cmd_o,
   input wire logic cmd_valid_o,
   input wire logic [2:0] mode_reg_sel_o,
   input wire logic [16:0] row_addr_o,
   input wire dcc_pkg::dcc_state_type state_o,
   input wire logic idle_o,
   input wire logic burst_active_o,
   input wire logic dll_enable_o,
   input wire logic [4:0] read_latency_o,
   input wire logic [4:0] write_latency_o,
   input wire logic [4:0] strobe_start_o,
   input wire logic odt_active_o,
   input wire logic self_refresh_o,
   input wire logic refresh_allowed_o,
   input wire logic illegal_o
);
   logic cke_d;
   logic exec;
   // Clock enable of the previous edge, held at its idle high level by reset
   always_ff @(posedge sys_clk_i) begin
      cke_d <= nrst_i ? cke_i : 1'b1;
   end
   // A selected command that the device takes at this edge
   assign exec = !cs_n_i && cke_i && cke_d && state_o == dcc_pkg::DCC_ST_ACTIVE;
   default clocking dcc_cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   a_act_row_capture: assert property (
      exec && !act_n_i |=> cmd_o == dcc_pkg::DCC_CMD_ACT &&
      row_addr_o == {$past(ras_n_i), $past(cas_n_i), $past(we_n_i), $past(addr_i)})
      else $error("row address not taken from shared pins");
   a_mode_select: assert property (
      exec && act_n_i && !ras_n_i && !cas_n_i && !we_n_i |=> cmd_o == dcc_pkg::DCC_CMD_MRS
      && mode_reg_sel_o == {$past(bg_i[0]), $past(ba_i)})
      else $error("mode register select wrong");
   a_des_quiet: assert property (
      cs_n_i |=> !cmd_valid_o)
      else $error("command executed while deselected");
   a_odt_gate: assert property (
      self_refresh_o |-> !odt_active_o)
      else $error("termination active in self refresh");
   a_pd_refresh: assert property (
      state_o inside {dcc_pkg::DCC_ST_PRE_PD, dcc_pkg::DCC_ST_ACT_PD} |-> !refresh_allowed_o)
      else $error("refresh allowed in power-down");
   a_loop_off_lat: assert property (
      !dll_enable_o |-> read_latency_o == 5'h0A && write_latency_o == 5'h09)
      else $error("loop-off latencies wrong");
   a_strobe_start: assert property (
      strobe_start_o == 5'(additive_latency_i + read_latency_o - {4'h0, !dll_enable_o}))
      else $error("strobe start wrong");
   a_pd_entry: assert property (
      cke_d && !cke_i && cs_n_i && idle_o |=> state_o == dcc_pkg::DCC_ST_PRE_PD)
      else $error("precharge power-down not entered");
   a_idle_def: assert property (
      idle_o |-> state_o == dcc_pkg::DCC_ST_ACTIVE && !burst_active_o && cke_d)
      else $error("idle reported while busy");
   a_rfu_flag: assert property (
      exec && act_n_i && !ras_n_i && cas_n_i && we_n_i |=> illegal_o)
      else $error("reserved command not flagged");
endmodule
`default_nettype wire

// [verification/dcc_ctl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Behavioural memory controller driving clock enable and command pins
module dcc_ctl_model #(
   parameter int GAP = dcc_pkg::DCC_CKE_CYC
) (
   input wire logic clk_i,
   output logic cke_o,
   output logic [4:0] pins_o,
   output logic [1:0] bg_o,
   output logic [1:0] ba_o,
   output logic [13:0] addr_o
);
   int cnt = 0;
   logic cke_q = 1'b1;
   // Pins {cs_n, act_n, ras_n, cas_n, we_n}; address bit 17 has no pin here
   initial begin
      cke_o = 1'b1;
      pins_o = 5'h1F;
      bg_o = 2'h0;
      ba_o = 2'h0;
      addr_o = 14'h0000;
   end
   // Edges since the last command or clock-enable change
   always @(posedge clk_i) begin
      cnt <= (cke_o !== cke_q || !pins_o[4]) ? 0 : cnt + 1;
      cke_q <= cke_o;
   end
   // One drive per edge, synchronous to the clock; enable held its least pulse time
   task automatic put(input logic k, input logic [4:0] p, input logic [1:0] g, b,
                      input logic [13:0] a);
      while (k !== cke_o && cnt < GAP) begin
         @(posedge clk_i);
         pins_o <= {1'b1, ~pins_o[3:0]};
      end
      @(posedge clk_i);
      cke_o <= k;
      pins_o <= p;
      bg_o <= g;
      ba_o <= b;
      addr_o <= a;
   endtask
   // Deselect, never the no-op, with released pins turned over
   task automatic des(input logic k);
      put(k, {1'b1, ~pins_o[3:0]}, ~bg_o, ~ba_o, ~addr_o);
   endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int XSDLL = 8;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic odt = 1'b0;
   logic [4:0] al = 5'h02;
   logic cke;
   logic [4:0] pins;
   logic [1:0] bg, ba;
   logic [13:0] addr;
   dcc_pkg::dcc_cmd_type cmd;
   dcc_pkg::dcc_state_type st;
   logic cmd_valid, idle, burst, dll, sref, rd_ok, odt_act, ref_ok, illegal;
   logic brd;
   logic [1:0] bgrp, bnk;
   logic [13:0] mop;
   logic [2:0] msel;
   logic [16:0] row;
   logic [4:0] rl, wl, strobe;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   // Clock at 100 ns
   always #50 sys_clk = ~sys_clk;
   dcc_ctl_model ctl (.clk_i(sys_clk), .cke_o(cke), .pins_o(pins), .bg_o(bg), .ba_o(ba),
      .addr_o(addr));
   dcc_top #(.XSDLL_CYC(XSDLL)) DUT (.sys_clk_i(sys_clk), .nrst_i(nrst), .cke_i(cke),
      .cs_n_i(pins[4]), .act_n_i(pins[3]), .ras_n_i(pins[2]), .cas_n_i(pins[1]),
      .we_n_i(pins[0]), .bg_i(bg), .ba_i(ba), .addr_i(addr), .odt_i(odt),
      .additive_latency_i(al), .cmd_o(cmd), .cmd_valid_o(cmd_valid), .bank_group_o(bgrp),
      .bank_o(bnk), .mode_reg_sel_o(msel), .row_addr_o(row), .mode_op_o(mop), .state_o(st),
      .idle_o(idle), .burst_active_o(burst), .burst_is_read_o(brd), .dll_enable_o(dll),
      .read_latency_o(rl), .write_latency_o(wl), .strobe_start_o(strobe),
      .odt_active_o(odt_act), .self_refresh_o(sref), .refresh_allowed_o(ref_ok),
      .read_allowed_o(rd_ok), .illegal_o(illegal));
   // Compare and count
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t ns %s", $time, msg);
      end
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Enter and leave power-down with deselect on both edges
   task automatic pd_cycle(input dcc_pkg::dcc_state_type exp);
      ctl.des(1'b0);
      ctl.des(1'b0);
      #1;
      chk(st === exp && ref_ok === 1'b0, "power-down state");
      ctl.des(1'b1);
      ctl.des(1'b1);
      #1;
      chk(st === dcc_pkg::DCC_ST_ACTIVE, "power-down exit");
   endtask
   task automatic t_reset;
      chk(cmd === dcc_pkg::DCC_CMD_DES && st === dcc_pkg::DCC_ST_ACTIVE, "reset");
      chk(dll === 1'b1 && rl === 5'h0A && wl === 5'h09, "reset mode");
      @(posedge sys_clk);
      #1;
      chk(illegal === 1'b0 && idle === 1'b1, "false edge after reset");
   endtask
   // Loop off then on through mode register one, picked by bank address
   task automatic t_mode;
      @(posedge sys_clk);
      al <= 5'h03;
      ctl.put(1'b1, 5'b01000, 2'h0, 2'h1, 14'h0000);
      ctl.des(1'b1);
      #1;
      chk(cmd === dcc_pkg::DCC_CMD_MRS && msel === 3'h1, "mode select");
      chk(cmd_valid === 1'b1, "mode command valid");
      chk(dll === 1'b0 && rl === 5'h0A && wl === 5'h09, "loop off");
      chk(strobe === 5'h0C, "loop-off strobe");
      ctl.put(1'b1, 5'b01000, 2'h0, 2'h1, 14'h0001);
      ctl.des(1'b1);
      #1;
      chk(dll === 1'b1 && strobe === 5'h0D, "loop on");
      chk(mop === 14'h0001, "mode operand");
   endtask
   task automatic t_row_pd;
      ctl.put(1'b1, 5'b00101, 2'h2, 2'h3, 14'h2A5A);
      ctl.des(1'b1);
      #1;
      chk(cmd === dcc_pkg::DCC_CMD_ACT && row === 17'h16A5A, "row capture");
      chk(bgrp === 2'h2 && bnk === 2'h3, "bank capture");
      chk(idle === 1'b0, "idle with open bank");
      pd_cycle(dcc_pkg::DCC_ST_ACT_PD);
   endtask
   // Back-to-back reads, burst runs on through deselects
   task automatic t_burst;
      ctl.put(1'b1, 5'b01101, 2'h2, 2'h3, 14'h0000);
      ctl.put(1'b1, 5'b01101, 2'h2, 2'h3, 14'h0000);
      ctl.des(1'b1);
      #1;
      chk(illegal === 1'b1 && burst === 1'b1, "read in burst");
      chk(brd === 1'b1, "read burst kind");
      for (int i = 0; i < 6 && burst !== 1'b0; i++) @(posedge sys_clk);
      #1;
      chk(burst === 1'b0, "burst end");
      ctl.put(1'b1, 5'b01010, 2'h0, 2'h0, 14'h0400);
      ctl.des(1'b1);
      #1;
      chk(cmd === dcc_pkg::DCC_CMD_PREA && idle === 1'b1, "all closed");
      pd_cycle(dcc_pkg::DCC_ST_PRE_PD);
      ctl.put(1'b1, 5'b01011, 2'h0, 2'h0, 14'h0000);
      ctl.des(1'b1);
      #1;
      chk(illegal === 1'b1, "reserved code");
   endtask
   // Self refresh from idle, termination gated, reads refused until locked
   task automatic t_selfref;
      @(posedge sys_clk);
      odt <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(odt_act === 1'b1, "termination follows pin");
      ctl.put(1'b0, 5'b01001, 2'h0, 2'h0, 14'h0000);
      ctl.des(1'b0);
      #1;
      chk(st === dcc_pkg::DCC_ST_SELF_REF && sref === 1'b1, "self refresh");
      chk(odt_act === 1'b0, "termination gated");
      // Termination stays low through the whole exit delay
      @(posedge sys_clk);
      odt <= 1'b0;
      ctl.des(1'b1);
      ctl.des(1'b1);
      #1;
      chk(st === dcc_pkg::DCC_ST_SR_EXIT && rd_ok === 1'b0, "exit");
      ctl.put(1'b1, 5'b01101, 2'h0, 2'h0, 14'h0000);
      ctl.des(1'b1);
      #1;
      chk(illegal === 1'b1, "read in exit");
      for (int i = 0; i < XSDLL + 8 && rd_ok !== 1'b1; i++) @(posedge sys_clk);
      #1;
      chk(rd_ok === 1'b1 && st === dcc_pkg::DCC_ST_ACTIVE, "locked exit");
   endtask
   // Cuts a hang short
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      t_reset();
      t_mode();
      t_row_pd();
      t_burst();
      t_selfref();
      complete_run();
   end
endmodule
bind dcc_top dcc_top_sva #(.XSDLL_CYC(XSDLL_CYC)) u_sva (.sys_clk_i, .nrst_i, .cke_i,
   .cs_n_i, .act_n_i, .ras_n_i, .cas_n_i, .we_n_i, .bg_i, .ba_i, .addr_i,
   .additive_latency_i, .cmd_o, .cmd_valid_o, .mode_reg_sel_o, .row_addr_o, .state_o,
   .idle_o, .burst_active_o, .dll_enable_o, .read_latency_o, .write_latency_o,
   .strobe_start_o, .odt_active_o, .self_refresh_o, .refresh_allowed_o, .illegal_o);
`default_nettype wire
